// ---- src/sacp_parser.sv ----
// Serial ASCII command line parser with response formatter.
`timescale 1ns/1ns
`default_nettype none
module sacp_parser #(
  parameter int unsigned ARG_W   = sacp_pkg::ARG_W_DEF,
  parameter int unsigned BIT_CYC = sacp_pkg::BIT_CYCLES
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Serial link pins.
  input  wire logic             rx_pin,
  output logic                  tx_pin,
  // Parsed command to the command logic.
  output logic                  cmd_valid,
  output logic [7:0]            cmd_letter,
  output logic [ARG_W-1:0]      first_numeric_arg,
  output logic [ARG_W-1:0]      second_numeric_arg,
  output logic [ARG_W-1:0]      third_numeric_arg,
  output logic [2:0]            arg_present,
  // Response from the command logic.
  input  wire logic             resp_valid,
  input  wire logic [7:0]       response_ident,
  input  wire logic [31:0]      resp_first,
  input  wire logic [31:0]      resp_second,
  input  wire logic [31:0]      resp_code,
  output logic                  resp_ready,
  // Operation trigger and frozen parameters.
  input  wire logic             op_trigger,
  output logic [ARG_W-1:0]      active_first_arg,
  output logic [ARG_W-1:0]      active_second_arg
);
  import sacp_pkg::*;

  // Accumulator must fit a 32-bit response; a bit period must fit the counters.
  if (ARG_W < 17 || ARG_W > 32 || BIT_CYC < 8 || BIT_CYC >= 2**CNT_W) begin : g_bad_width
    $error("ARG_W must lie in 17..32 and BIT_CYC in 8..65535");
  end

  // Receiver and transmitter links.
  logic                         rx_valid;
  logic [7:0]                   rx_data;
  logic                         tx_valid;
  logic                         tx_ready;
  logic [7:0]                   tx_char;

  // Parse state of the current line.
  sacp_phase_t                  phase;
  logic [7:0]                   letter;
  logic                         any_char;
  logic                         bad_char;
  logic                         second_letter;
  logic [ARG_W-1:0]             acc [3];
  logic [2:0]                   present;

  // Character classes of the received byte.
  logic                         is_cr;
  logic                         is_digit;
  logic                         is_comma;
  logic                         is_alpha;
  logic                         take;
  logic                         eol;
  logic                         lone_cr;
  logic                         good_letter;
  logic                         line_error;
  logic                         line_warn;
  logic                         line_ok;
  logic [ARG_W-1:0]             digit_acc [3];

  // Formatter state.
  sacp_tx_t                     tx_state;
  logic [2:0]                   field;
  logic [7:0]                   r_ident;
  logic [31:0]                  r_val [3];
  logic [31:0]                  rem;
  logic [3:0]                   pos;
  logic [3:0]                   dig;
  logic                         started;
  logic                         ret_digit;
  logic [31:0]                  pow_now;

  // Staged parameters from the latest accepted command.
  logic [ARG_W-1:0]             staged_first;
  logic [ARG_W-1:0]             staged_second;

  // Powers of ten for the decimal digits of a response value.
  function automatic logic [31:0] pow10(input logic [3:0] p);
    logic [31:0] v;
    v = 32'h0000_0001;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < p) v = (v << 3) + (v << 1);
    end
    return v;
  endfunction

  // Appends one decimal digit to an unsigned accumulator.
  function automatic logic [ARG_W-1:0] add_digit(input logic [ARG_W-1:0] a,
                                                input logic [7:0]       c);
    logic [ARG_W+3:0] w;
    w = ({4'h0, a} << 3) + ({4'h0, a} << 1) + (ARG_W+4)'(c - CH_ZERO);
    return w[ARG_W-1:0];
  endfunction

  sacp_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk        (clk),
    .rst_b      (rst_b),
    .rx_pin     (rx_pin),
    .byte_valid (rx_valid),
    .byte_data  (rx_data)
  );

  sacp_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk        (clk),
    .rst_b      (rst_b),
    .in_valid   (tx_valid),
    .in_data    (tx_char),
    .in_ready   (tx_ready),
    .tx_pin     (tx_pin)
  );

  // Classify the received byte; bytes arriving during a response are dropped.
  assign is_cr    = (rx_data == CH_CR);
  assign is_digit = (rx_data >= CH_ZERO) && (rx_data <= CH_NINE);
  assign is_comma = (rx_data == CH_COMMA);
  assign is_alpha = ((rx_data >= CH_LO_A) && (rx_data <= CH_LO_Z)) ||
                    ((rx_data >= CH_UP_A) && (rx_data <= CH_UP_Z));
  assign take     = rx_valid && (tx_state == TX_IDLE);
  assign eol      = take && is_cr;

  // Outcome of a completed line.
  assign lone_cr     = !any_char;
  assign good_letter = (phase != PH_SEEK) &&
                       (letter >= CH_LO_A) && (letter <= CH_LO_Z);
  assign line_error  = !lone_cr && (!good_letter || (bad_char && !second_letter));
  assign line_warn   = !lone_cr && good_letter && second_letter;
  assign line_ok     = !lone_cr && good_letter && !second_letter && !bad_char;

  // Digit accumulation for each argument slot.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      digit_acc[i] = add_digit(acc[i], rx_data);
    end
  end

  // Line parser; a carriage return resets it for the next line.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase         <= PH_SEEK;
      letter        <= 8'h00;
      any_char      <= 1'b0;
      bad_char      <= 1'b0;
      second_letter <= 1'b0;
      present       <= 3'h0;
      for (int i = 0; i < 3; i++) acc[i] <= '0;
    end else if (eol) begin
      phase         <= PH_SEEK;
      any_char      <= 1'b0;
      bad_char      <= 1'b0;
      second_letter <= 1'b0;
      present       <= 3'h0;
      for (int i = 0; i < 3; i++) acc[i] <= '0;
    end else if (take) begin
      any_char <= 1'b1;
      unique case (phase)
        PH_SEEK: begin
          // Anything before the first letter is discarded.
          if (is_alpha) begin
            letter <= rx_data;
            phase  <= PH_ARG1;
          end
        end
        PH_ARG1: begin
          if (is_alpha) second_letter <= 1'b1;
          else if (is_digit) begin
            acc[0]     <= digit_acc[0];
            present[0] <= 1'b1;
          end else if (is_comma) begin
            present[0] <= 1'b1;
            phase      <= PH_ARG2;
          end else bad_char <= 1'b1;
        end
        PH_ARG2: begin
          if (is_alpha) second_letter <= 1'b1;
          else if (is_digit) begin
            acc[1]     <= digit_acc[1];
            present[1] <= 1'b1;
          end else if (is_comma) begin
            present[1] <= 1'b1;
            phase      <= PH_ARG3;
          end else bad_char <= 1'b1;
        end
        PH_ARG3: begin
          if (is_alpha) second_letter <= 1'b1;
          else if (is_digit) begin
            acc[2]     <= digit_acc[2];
            present[2] <= 1'b1;
          end else bad_char <= 1'b1;
        end
      endcase
    end
  end

  // Hand a clean line to the command logic as a one-cycle pulse.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_valid          <= 1'b0;
      cmd_letter         <= 8'h00;
      first_numeric_arg  <= '0;
      second_numeric_arg <= '0;
      third_numeric_arg  <= '0;
      arg_present        <= 3'h0;
    end else begin
      cmd_valid <= eol && line_ok;
      if (eol && line_ok) begin
        cmd_letter         <= letter;
        first_numeric_arg  <= acc[0];
        second_numeric_arg <= acc[1];
        third_numeric_arg  <= acc[2];
        arg_present        <= present;
      end
    end
  end

  // Staged values follow accepted commands; active values move only on a trigger.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      staged_first      <= '0;
      staged_second     <= '0;
      active_first_arg  <= '0;
      active_second_arg <= '0;
    end else begin
      if (cmd_valid) begin
        staged_first  <= first_numeric_arg;
        staged_second <= second_numeric_arg;
      end
      if (op_trigger) begin
        active_first_arg  <= staged_first;
        active_second_arg <= staged_second;
      end
    end
  end

  // Handshakes of the formatter.
  assign resp_ready = (tx_state == TX_WAIT);
  assign tx_valid   = (tx_state == TX_PUT);
  assign pow_now    = pow10(pos);

  // Response formatter: ident, value, comma, value, comma, code, CR.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_state  <= TX_IDLE;
      field     <= FLD_IDENT;
      r_ident   <= 8'h00;
      for (int i = 0; i < 3; i++) r_val[i] <= 32'h0000_0000;
      rem       <= 32'h0000_0000;
      pos       <= 4'h0;
      dig       <= 4'h0;
      started   <= 1'b0;
      ret_digit <= 1'b0;
      tx_char   <= 8'h00;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          // Nothing leaves the device except as the answer to a full line.
          if (eol) begin
            for (int i = 0; i < 3; i++) r_val[i] <= 32'h0000_0000;
            if (lone_cr) begin
              field    <= FLD_CR;
              tx_state <= TX_FIELD;
            end else if (line_ok) begin
              tx_state <= TX_WAIT;
            end else begin
              field    <= FLD_IDENT;
              r_ident  <= line_error ? ERR_IDENT : letter;
              r_val[2] <= line_warn ? WARN_CODE : ERR_CODE;
              tx_state <= TX_FIELD;
            end
          end
        end
        TX_WAIT: begin
          if (resp_valid) begin
            field    <= FLD_IDENT;
            r_ident  <= response_ident;
            r_val[0] <= resp_first;
            r_val[1] <= resp_second;
            r_val[2] <= resp_code;
            tx_state <= TX_FIELD;
          end
        end
        TX_FIELD: begin
          ret_digit <= 1'b0;
          unique case (field)
            FLD_IDENT: begin
              tx_char  <= r_ident;
              field    <= field + 1'b1;
              tx_state <= TX_PUT;
            end
            3'h1, 3'h3, 3'h5: begin
              rem      <= r_val[field[2:1]];
              pos      <= TOP_DIGIT;
              dig      <= 4'h0;
              started  <= 1'b0;
              tx_state <= TX_DIGIT;
            end
            3'h2, 3'h4: begin
              tx_char  <= CH_COMMA;
              field    <= field + 1'b1;
              tx_state <= TX_PUT;
            end
            FLD_CR: begin
              tx_char  <= CH_CR;
              field    <= FLD_DONE;
              tx_state <= TX_PUT;
            end
            FLD_DONE: tx_state <= TX_IDLE;
          endcase
        end
        TX_DIGIT: begin
          // Count subtractions of the current power, then emit the digit.
          if (rem >= pow_now) begin
            rem <= rem - pow_now;
            dig <= dig + 1'b1;
          end else begin
            dig <= 4'h0;
            if (pos == 4'h0) begin
              field     <= field + 1'b1;
              ret_digit <= 1'b0;
            end else begin
              pos       <= pos - 1'b1;
              ret_digit <= 1'b1;
            end
            if (dig != 4'h0 || started || pos == 4'h0) begin
              tx_char  <= CH_ZERO + {4'h0, dig};
              started  <= 1'b1;
              tx_state <= TX_PUT;
            end
          end
        end
        TX_PUT: begin
          if (tx_ready) tx_state <= ret_digit ? TX_DIGIT : TX_FIELD;
        end
      endcase
    end
  end
endmodule // sacp_parser
`default_nettype wire

// ---- src/sacp_pkg.sv ----
// Shared constants and state types for the serial ASCII command parser.
package sacp_pkg;

  // Clock and serial framing: 8 data bits, no parity, one stop bit.
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned BAUD_RATE   = 9600;
  localparam int unsigned BIT_CYCLES  = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int unsigned HALF_CYCLES = BIT_CYCLES / 2;
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned FRAME_BITS  = 10;
  localparam int unsigned CNT_W       = 16;

  // Characters the parser and the response formatter care about.
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_LO_A  = 8'h61;
  localparam logic [7:0] CH_LO_Z  = 8'h7A;
  localparam logic [7:0] CH_UP_A  = 8'h41;
  localparam logic [7:0] CH_UP_Z  = 8'h5A;

  // Identifier and codes of the responses the parser makes on its own.
  localparam logic [7:0]  ERR_IDENT = 8'h3F;
  localparam logic [31:0] ERR_CODE  = 32'h0000_0001;
  localparam logic [31:0] WARN_CODE = 32'h0000_0002;

  // Argument width and decimal digits of a 32-bit response value.
  localparam int unsigned ARG_W_DEF  = 32;
  localparam logic [3:0]  TOP_DIGIT  = 4'h9;
  localparam logic [2:0]  FLD_IDENT  = 3'h0;
  localparam logic [2:0]  FLD_CR     = 3'h6;
  localparam logic [2:0]  FLD_DONE   = 3'h7;

  // Parse phase of the current line.
  typedef enum logic [3:0] {
    PH_SEEK = 4'b0001,
    PH_ARG1 = 4'b0010,
    PH_ARG2 = 4'b0100,
    PH_ARG3 = 4'b1000
  } sacp_phase_t;

  // Response formatter states.
  typedef enum logic [4:0] {
    TX_IDLE  = 5'b00001,
    TX_WAIT  = 5'b00010,
    TX_FIELD = 5'b00100,
    TX_DIGIT = 5'b01000,
    TX_PUT   = 5'b10000
  } sacp_tx_t;

  // Receiver states.
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } sacp_rx_t;

endpackage

// ---- src/sacp_uart_rx.sv ----
// Asynchronous serial receiver, one byte per frame.
`timescale 1ns/1ns
`default_nettype none
module sacp_uart_rx #(
  // Clock cycles per serial bit.
  parameter int unsigned BIT_CYC = sacp_pkg::BIT_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Serial data pin from the host.
  input  wire logic       rx_pin,
  // Received byte.
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  import sacp_pkg::*;

  logic                   sync1;
  logic                   sync2;
  sacp_rx_t               state;
  logic [CNT_W-1:0]       cnt;
  logic [2:0]             bitn;
  logic [7:0]             shreg;

  // Two-stage synchroniser on the pin.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= rx_pin;
      sync2 <= sync1;
    end
  end

  // Frame sampler at mid-bit; a bad start or stop bit drops the frame.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state      <= RX_IDLE;
      cnt        <= '0;
      bitn       <= 3'h0;
      shreg      <= 8'h00;
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      unique case (state)
        RX_IDLE: begin
          cnt <= '0;
          if (!sync2) state <= RX_START;
        end
        RX_START: begin
          if (cnt == CNT_W'(BIT_CYC / 2 - 1)) begin
            cnt   <= '0;
            bitn  <= 3'h0;
            state <= sync2 ? RX_IDLE : RX_DATA;
          end else cnt <= cnt + 1'b1;
        end
        RX_DATA: begin
          if (cnt == CNT_W'(BIT_CYC - 1)) begin
            cnt   <= '0;
            shreg <= {sync2, shreg[7:1]};
            bitn  <= bitn + 1'b1;
            if (bitn == 3'(DATA_BITS - 1)) state <= RX_STOP;
          end else cnt <= cnt + 1'b1;
        end
        RX_STOP: begin
          if (cnt == CNT_W'(BIT_CYC - 1)) begin
            byte_valid <= sync2;
            byte_data  <= shreg;
            state      <= RX_IDLE;
          end else cnt <= cnt + 1'b1;
        end
      endcase
    end
  end
endmodule // sacp_uart_rx
`default_nettype wire

// ---- src/sacp_uart_tx.sv ----
// Asynchronous serial transmitter, one byte per frame.
`timescale 1ns/1ns
`default_nettype none
module sacp_uart_tx #(
  // Clock cycles per serial bit.
  parameter int unsigned BIT_CYC = sacp_pkg::BIT_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Byte to send.
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  // Serial data pin to the host.
  output logic            tx_pin
);
  import sacp_pkg::*;

  logic [8:0]             shreg;
  logic [3:0]             bits_left;
  logic [CNT_W-1:0]       cnt;

  // Ready only once the previous stop bit has fully gone out.
  assign in_ready = (bits_left == 4'h0);

  // Start bit, eight data bits LSB first, one stop bit, no parity.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      shreg     <= 9'h1FF;
      bits_left <= 4'h0;
      cnt       <= '0;
      tx_pin    <= 1'b1;
    end else if (in_ready) begin
      cnt <= '0;
      if (in_valid) begin
        shreg     <= {1'b1, in_data};
        bits_left <= 4'(FRAME_BITS);
        tx_pin    <= 1'b0;
      end
    end else if (cnt == CNT_W'(BIT_CYC - 1)) begin
      cnt       <= '0;
      bits_left <= bits_left - 1'b1;
      tx_pin    <= (bits_left == 4'h1) ? 1'b1 : shreg[0];
      shreg     <= {1'b1, shreg[8:1]};
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // sacp_uart_tx
`default_nettype wire

// ---- tb/sacp_parser_monitor.sv ----
// Concurrent checks on the ports of the serial ASCII command parser.
`timescale 1ns/1ns
`default_nettype none
module sacp_parser_monitor #(
  parameter int unsigned ARG_W = 32
) (
  // Clock and reset.
  input wire logic             clk,
  input wire logic             rst_b,
  // Serial output and parsed command.
  input wire logic             tx_pin,
  input wire logic             cmd_valid,
  input wire logic [ARG_W-1:0] first_numeric_arg,
  input wire logic [ARG_W-1:0] second_numeric_arg,
  // Response handshake.
  input wire logic             resp_valid,
  input wire logic             resp_ready,
  // Operation freeze.
  input wire logic             op_trigger,
  input wire logic [ARG_W-1:0] active_first_arg,
  input wire logic [ARG_W-1:0] active_second_arg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A finished line gives a single command pulse.
  property p_cmd_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmd_valid wider than one cycle");

  // A command opens the wait for its response at once.
  property p_cmd_ready;
    cmd_valid |-> resp_ready;
  endproperty
  a_cmd_ready: assert property (p_cmd_ready) else $error("resp_ready missing at command");

  // The wait is held until the response is taken.
  property p_ready_hold;
    resp_ready && !resp_valid |=> resp_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("resp_ready dropped early");

  // A taken response closes the wait for the next eight cycles.
  property p_ready_drop;
    resp_ready && resp_valid |=> !resp_ready [*8];
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("resp_ready high during reply");

  // The reply starts two to three cycles after it is taken.
  property p_tx_start;
    resp_ready && resp_valid |-> tx_pin ##[2:3] !tx_pin;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("reply start bit late");

  // Nothing is sent while the parser waits for a response.
  property p_quiet_wait;
    resp_ready |-> tx_pin;
  endproperty
  a_quiet_wait: assert property (p_quiet_wait) else $error("tx active while waiting");

  // Frozen parameters move only on a trigger.
  property p_freeze_hold;
    !op_trigger |=> $stable(active_first_arg) && $stable(active_second_arg);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("frozen values changed");

  // A trigger freezes the arguments of the last command.
  property p_freeze_load;
    op_trigger && !cmd_valid |=> active_first_arg == $past(first_numeric_arg)
      && active_second_arg == $past(second_numeric_arg);
  endproperty
  a_freeze_load: assert property (p_freeze_load) else $error("trigger froze wrong values");

  // The first argument changes only with a command pulse.
  property p_args_held;
    $changed(first_numeric_arg) |-> cmd_valid;
  endproperty
  a_args_held: assert property (p_args_held) else $error("argument moved without command");

  // Main scenarios reached.
  c_cmd: cover property (cmd_valid);
  c_resp: cover property (resp_valid && resp_ready);
  c_trig: cover property (op_trigger);
endmodule // sacp_parser_monitor
`default_nettype wire

// ---- tb/sacp_host_model.sv ----
// Host terminal model: sends 8N1 command lines and collects reply bytes.
`timescale 1ns/1ns
`default_nettype none
module sacp_host_model #(
  parameter int unsigned BIT_CYC = sacp_pkg::BIT_CYCLES
) (
  // Clock.
  input  wire logic clk,
  // Link pins as named at the parser; no handshake lines exist.
  output logic      rx_pin,
  input  wire logic tx_pin
);
  import sacp_pkg::*;
  logic [7:0] rx_q[$];
  logic [7:0] sh;

  // The line idles at mark level.
  initial rx_pin = 1'b1;

  // Sends one frame, start bit, data LSB first, one stop bit, no parity.
  task automatic send_byte(input logic [7:0] b, input int gap);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < FRAME_BITS; i++) begin
      @(posedge clk);
      #1 rx_pin = fr[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    repeat (gap) @(posedge clk);
  endtask

  // Sends a line; local echo stays in the host, nothing returns per char.
  task automatic send_line(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) send_byte(s[i], gap);
    send_byte(CH_CR, gap);
  endtask

  // Receives reply frames mid-bit; bad stop bits are dropped.
  always begin
    @(negedge tx_pin);
    repeat (BIT_CYC / 2) @(posedge clk);
    if (tx_pin === 1'b0) begin
      for (int i = 0; i < DATA_BITS; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        sh[i] = tx_pin;
      end
      repeat (BIT_CYC) @(posedge clk);
      if (tx_pin === 1'b1) rx_q.push_back(sh);
    end
  end
endmodule // sacp_host_model
`default_nettype wire

// ---- tb/sacp_parser_tb_top.sv ----
// Self-checking bench for the serial ASCII command parser.
`timescale 1ns/1ns
`default_nettype none
module sacp_parser_tb_top;
  import sacp_pkg::*;
  localparam int unsigned ARG_W = 32;
  // Short bit period keeps the run brief; the framing logic is unchanged.
  localparam int unsigned BIT_CYC = 32;
  logic             clk = 1'b0;
  logic             rst_b = 1'b0;
  logic             rx_pin;
  logic             tx_pin;
  logic             cmd_valid;
  logic [7:0]       cmd_letter;
  logic [ARG_W-1:0] first_numeric_arg;
  logic [ARG_W-1:0] second_numeric_arg;
  logic [ARG_W-1:0] third_numeric_arg;
  logic [2:0]       arg_present;
  logic             resp_valid = 1'b0;
  logic [7:0]       response_ident = 8'h00;
  logic [31:0]      resp_first = 32'h0;
  logic [31:0]      resp_second = 32'h0;
  logic [31:0]      resp_code = 32'h0;
  logic             resp_ready;
  logic             op_trigger = 1'b0;
  logic [ARG_W-1:0] active_first_arg;
  logic [ARG_W-1:0] active_second_arg;
  int               mismatches = 0;
  int               tests_run = 0;
  int               n_cmd;

  // 10 MHz clock.
  always #50 clk = ~clk;

  sacp_parser #(.ARG_W(ARG_W), .BIT_CYC(BIT_CYC)) uut (.clk, .rst_b, .rx_pin, .tx_pin, .cmd_valid,
    .cmd_letter,
    .first_numeric_arg, .second_numeric_arg, .third_numeric_arg, .arg_present, .resp_valid,
    .response_ident, .resp_first, .resp_second, .resp_code, .resp_ready, .op_trigger,
    .active_first_arg, .active_second_arg);

  sacp_host_model #(.BIT_CYC(BIT_CYC)) host (.clk, .rx_pin, .tx_pin);

  // Counts command pulses since the last reset.
  always @(posedge clk) begin
    if (!rst_b) n_cmd <= 0;
    else if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
      mismatches++;
    end
  endtask

  // Waits, bounded, for n reply characters; an extra one means an echo.
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (host.rx_q.size() < n && k < 12 * BIT_CYC * n) begin
      @(posedge clk);
      k++;
    end
    chk("reply chars", n, host.rx_q.size());
    if (host.rx_q.size() < n) stop_test();
  endtask

  // Waits, bounded, until n command pulses have been seen since reset.
  task automatic wait_cmd(input int n);
    int k;
    k = 0;
    #1;
    while (n_cmd < n && k < 3 * BIT_CYC) begin
      @(posedge clk);
      k++;
    end
    chk("cmd count", n, n_cmd);
    if (n_cmd < n) stop_test();
    #1;
  endtask

  // Synchronous reset held for two cycles; drops any pending reply.
  task automatic do_reset();
    @(posedge clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    host.rx_q.delete();
  endtask

  // One-cycle operation trigger.
  task automatic pulse_trigger();
    @(posedge clk);
    #1 op_trigger = 1'b1;
    @(posedge clk);
    #1 op_trigger = 1'b0;
  endtask

  // A line holding only a carriage return is answered by one.
  task automatic bare_cr();
    host.send_line("", 0);
    wait_rx(1);
    chk("cr reply", CH_CR, host.rx_q[0]);
    chk("cmd count", 0, n_cmd);
    repeat (BIT_CYC) @(posedge clk);
    host.rx_q.delete();
  endtask

  // Junk before the letter, slow host, full reply after a freeze.
  task automatic junk_letter();
    string exp;
    host.send_line("#c9,", 2000);
    wait_cmd(1);
    chk("no echo", 0, host.rx_q.size());
    chk("letter", 8'h63, cmd_letter);
    chk("arg1", 9, first_numeric_arg);
    chk("present", 3'b001, arg_present);
    chk("ready", 1, resp_ready);
    pulse_trigger();
    chk("active1", 9, active_first_arg);
    response_ident = 8'h63;
    resp_first = 32'h5;
    resp_valid = 1'b1;
    @(posedge clk);
    #1 resp_valid = 1'b0;
    wait_rx(7);
    exp = "c5,0,0";
    for (int i = 0; i < 6; i++) chk("reply char", exp[i], host.rx_q[i]);
    chk("reply end", CH_CR, host.rx_q[6]);
    repeat (BIT_CYC) @(posedge clk);
    host.rx_q.delete();
  endtask

  // Empty fields read as zero; new values wait for the next trigger.
  task automatic empty_fields();
    host.send_line("z,,7", 0);
    wait_cmd(2);
    chk("arg1", 0, first_numeric_arg);
    chk("arg2", 0, second_numeric_arg);
    chk("arg3", 7, third_numeric_arg);
    chk("present", 3'b111, arg_present);
    chk("held", 9, active_first_arg);
    pulse_trigger();
    chk("active1", 0, active_first_arg);
    chk("active2", 0, active_second_arg);
    do_reset();
  endtask

  // A refused line: the whole error or warning reply is checked.
  task automatic bad_line(input string s, input string exp);
    host.send_line(s, 0);
    wait_rx(7);
    for (int i = 0; i < 6; i++) chk("reply char", exp[i], host.rx_q[i]);
    chk("reply end", CH_CR, host.rx_q[6]);
    chk("cmd count", 0, n_cmd);
    do_reset();
  endtask

  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge clk);
    bare_cr();
    junk_letter();
    empty_fields();
    bad_line("ab", "a0,0,2");
    bad_line("A", "?0,0,1");
    bad_line("d1\010", "?0,0,1");
    stop_test();
  end
endmodule // sacp_parser_tb_top

bind sacp_parser sacp_parser_monitor #(.ARG_W(ARG_W)) u_mon (.clk, .rst_b, .tx_pin, .cmd_valid,
  .first_numeric_arg, .second_numeric_arg, .resp_valid, .resp_ready, .op_trigger,
  .active_first_arg, .active_second_arg);
`default_nettype wire
